// ===== logic/tsf_flags.sv
/*
 * status flags and interrupt enables of timer channel 1, both register sets.
 * assumes: apb master on the core clock; match, capture and transfer-controller
 * start strobes are single-cycle pulses from logic on the same clock.
 */
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps

// How it works
// - enable b bit 3 gates the dedicated compare 4 interrupt, reset 0.
// - enable b bit 2 gates the dedicated compare 3 interrupt, reset 0.
// - enable b bit 1 gates the general register 4 interrupt, reset 0.
// - enable b bit 0 gates the general register 3 interrupt, reset 0.
// - an interrupt request is raised while a flag and its enable are both 1.
// - status a bits 7 to 5 read as 1 and are read-only.
// - status a bit 4 sets when the 16-bit counter wraps from maximum to zero.
// - a flag clears on a 0 write after it was read as 1; resets to 0.
// - status a bit 3 sets on counter equal to dedicated register 2.
// - status a bit 2 sets on counter equal to dedicated register 1.
// - status a bit 1 sets on general register 2 match or capture.
// - status a bit 0 sets on general register 1 match or capture.
// - match and capture flags clear when their interrupt starts a transfer.
// - channel 1 carries two status registers, a and b.
// - status b bits 7 to 4 read as 1, read-only; bits 3 to 0 reset 0.
// - status b bit 3 sets on counter equal to dedicated register 4.
// - status b bit 2 sets on counter equal to dedicated register 3.
// - status b bit 1 sets on general register 4 match or capture.
// - status b bit 0 sets on general register 3 match or capture.
module tsf_flags
  import tsf_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_ARST_N,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_prdata_unused_guard,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // counter and event strobes
  input wire logic [15:0] I_COUNT,
  input wire logic I_COUNT_TICK,
  input wire logic I_DCMP_1_MATCH,
  input wire logic I_DCMP_2_MATCH,
  input wire logic I_DCMP_3_MATCH,
  input wire logic I_DCMP_4_MATCH,
  input wire logic I_GEN_1_EVENT,
  input wire logic I_GEN_2_EVENT,
  input wire logic I_GEN_3_EVENT,
  input wire logic I_GEN_4_EVENT,
  // transfer-controller starts, one per match or capture source
  input wire logic [3:0] I_XFER_START_A,
  input wire logic [3:0] I_XFER_START_B,
  // interrupt requests
  output logic [4:0] O_IRQ_A,
  output logic [3:0] O_IRQ_B
);

  // ****************************************
  // state
  // ****************************************
  logic [4:0] irq_en_a_q;
  logic [3:0] irq_en_b_q;
  logic [4:0] status_a_q;
  logic [3:0] status_b_q;
  logic [4:0] armed_a_q;
  logic [3:0] armed_b_q;
  logic [15:0] count_prev_q;
  logic [4:0] set_a;
  logic [3:0] set_b;
  logic [4:0] clr_a;
  logic [3:0] clr_b;
  logic [4:0] dtc_a;
  logic access;
  logic wr_ok;
  logic hit_ena;
  logic hit_enb;
  logic hit_sta;
  logic hit_stb;
  logic mapped;
  logic [7:0] rd_byte;
  logic wr_ena;
  logic wr_enb;
  logic wr_sta;
  logic wr_stb;
  logic rd_sta_setup;
  logic rd_stb_setup;
  logic wrap_seen;
  logic [7:0] byte_ena;
  logic [7:0] byte_enb;
  logic [7:0] byte_sta;
  logic [7:0] byte_stb;
  // named fields of the four registers
  logic overflow_flag;
  logic dedicated_cmp_2_flag;
  logic dedicated_cmp_1_flag;
  logic general_2_event_flag;
  logic general_1_event_flag;
  logic dedicated_cmp_4_flag;
  logic dedicated_cmp_3_flag;
  logic general_4_event_flag;
  logic general_3_event_flag;
  logic overflow_irq_en;
  logic dedicated_cmp_2_irq_en;
  logic dedicated_cmp_1_irq_en;
  logic general_2_irq_en;
  logic general_1_irq_en;
  logic dedicated_cmp_4_irq_en;
  logic dedicated_cmp_3_irq_en;
  logic general_4_irq_en;
  logic general_3_irq_en;

  // ****************************************
  // apb decode
  // ****************************************
  // single-cycle access phase: pready is registered high on the setup edge, so every access ends
  // in its first penable cycle
  assign access = i_psel & i_penable;
  assign hit_ena = (i_paddr[11:4] == 8'h00) && (i_paddr[3:0] == TSF_OFS_IRQ_EN_A);
  assign hit_enb = (i_paddr[11:4] == 8'h00) && (i_paddr[3:0] == TSF_OFS_IRQ_EN_B);
  assign hit_sta = (i_paddr[11:4] == 8'h00) && (i_paddr[3:0] == TSF_OFS_STATUS_A);
  assign hit_stb = (i_paddr[11:4] == 8'h00) && (i_paddr[3:0] == TSF_OFS_STATUS_B);
  assign mapped = hit_ena | hit_enb | hit_sta | hit_stb;
  // only byte lane 0 carries register data
  assign wr_ok = access & i_pwrite & mapped & i_pstrb[0];
  assign wr_ena = wr_ok & hit_ena;
  assign wr_enb = wr_ok & hit_enb;
  assign wr_sta = wr_ok & hit_sta;
  assign wr_stb = wr_ok & hit_stb;
  // arming happens on the setup edge, the edge that latches the read data,
  // so only bits the master really saw as 1 can be cleared later
  assign rd_sta_setup = i_psel & ~i_penable & ~i_pwrite & hit_sta;
  assign rd_stb_setup = i_psel & ~i_penable & ~i_pwrite & hit_stb;

  // ****************************************
  // event sources
  // ****************************************
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      count_prev_q <= TSF_CNT_ZERO;
    end else begin
      count_prev_q <= I_COUNT;
    end
  end

  // wrap seen as max followed by zero on a counting tick
  assign wrap_seen = I_COUNT_TICK && (count_prev_q == TSF_CNT_MAX)
                     && (I_COUNT == TSF_CNT_ZERO);

  always_comb begin
    set_a = '0;
    set_b = '0;
    set_a[TSF_BIT_OVF] = wrap_seen;
    set_a[TSF_BIT_DCMP_HI] = I_DCMP_2_MATCH;
    set_a[TSF_BIT_DCMP_LO] = I_DCMP_1_MATCH;
    set_a[TSF_BIT_GEN_HI] = I_GEN_2_EVENT;
    set_a[TSF_BIT_GEN_LO] = I_GEN_1_EVENT;
    set_b[TSF_BIT_DCMP_HI] = I_DCMP_4_MATCH;
    set_b[TSF_BIT_DCMP_LO] = I_DCMP_3_MATCH;
    set_b[TSF_BIT_GEN_HI] = I_GEN_4_EVENT;
    set_b[TSF_BIT_GEN_LO] = I_GEN_3_EVENT;
  end

  // ****************************************
  // clear terms
  // ****************************************
  // overflow has no transfer-controller clear
  assign dtc_a = {1'b0, I_XFER_START_A};

  always_comb begin
    // a 0 clears only a bit armed by an earlier read of 1; writing 1 does
    // nothing
    clr_a = '0;
    clr_b = '0;
    if (wr_sta) begin
      clr_a = armed_a_q & ~i_pwdata[TSF_A_BITS-1:0];
    end
    if (wr_stb) begin
      clr_b = armed_b_q & ~i_pwdata[TSF_B_BITS-1:0];
    end
    clr_a = clr_a | (dtc_a & status_a_q);
    clr_b = clr_b | (I_XFER_START_B & status_b_q);
  end

  // ****************************************
  // flags, two register sets
  // ****************************************
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      status_a_q <= '0;
    end else begin
      // set term last so it wins over the clear
      status_a_q <= (status_a_q & ~clr_a) | set_a;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      status_b_q <= '0;
    end else begin
      status_b_q <= (status_b_q & ~clr_b) | set_b;
    end
  end

  // read-of-one arming; a flag dropped by other means disarms itself
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      armed_a_q <= '0;
    end else begin
      if (rd_sta_setup) begin
        armed_a_q <= status_a_q & ~clr_a;
      end else begin
        armed_a_q <= armed_a_q & status_a_q & ~clr_a;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      armed_b_q <= '0;
    end else begin
      if (rd_stb_setup) begin
        armed_b_q <= status_b_q & ~clr_b;
      end else begin
        armed_b_q <= armed_b_q & status_b_q & ~clr_b;
      end
    end
  end

  // ****************************************
  // interrupt enables
  // ****************************************
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      irq_en_a_q <= '0;
    end else begin
      if (wr_ena) begin
        irq_en_a_q <= i_pwdata[TSF_A_BITS-1:0];
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      irq_en_b_q <= '0;
    end else begin
      if (wr_enb) begin
        irq_en_b_q <= i_pwdata[TSF_B_BITS-1:0];
      end
    end
  end

  // ****************************************
  // named fields
  // ****************************************
  assign overflow_flag = status_a_q[TSF_BIT_OVF];
  assign dedicated_cmp_2_flag = status_a_q[TSF_BIT_DCMP_HI];
  assign dedicated_cmp_1_flag = status_a_q[TSF_BIT_DCMP_LO];
  assign general_2_event_flag = status_a_q[TSF_BIT_GEN_HI];
  assign general_1_event_flag = status_a_q[TSF_BIT_GEN_LO];
  assign dedicated_cmp_4_flag = status_b_q[TSF_BIT_DCMP_HI];
  assign dedicated_cmp_3_flag = status_b_q[TSF_BIT_DCMP_LO];
  assign general_4_event_flag = status_b_q[TSF_BIT_GEN_HI];
  assign general_3_event_flag = status_b_q[TSF_BIT_GEN_LO];
  assign overflow_irq_en = irq_en_a_q[TSF_BIT_OVF];
  assign dedicated_cmp_2_irq_en = irq_en_a_q[TSF_BIT_DCMP_HI];
  assign dedicated_cmp_1_irq_en = irq_en_a_q[TSF_BIT_DCMP_LO];
  assign general_2_irq_en = irq_en_a_q[TSF_BIT_GEN_HI];
  assign general_1_irq_en = irq_en_a_q[TSF_BIT_GEN_LO];
  assign dedicated_cmp_4_irq_en = irq_en_b_q[TSF_BIT_DCMP_HI];
  assign dedicated_cmp_3_irq_en = irq_en_b_q[TSF_BIT_DCMP_LO];
  assign general_4_irq_en = irq_en_b_q[TSF_BIT_GEN_HI];
  assign general_3_irq_en = irq_en_b_q[TSF_BIT_GEN_LO];

  // ****************************************
  // interrupt requests
  // ****************************************
  // registered for a clean output; request trails the flag by one cycle
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_IRQ_A <= '0;
      O_IRQ_B <= '0;
    end else begin
      O_IRQ_A[TSF_BIT_OVF] <= overflow_flag & overflow_irq_en;
      O_IRQ_A[TSF_BIT_DCMP_HI] <= dedicated_cmp_2_flag & dedicated_cmp_2_irq_en;
      O_IRQ_A[TSF_BIT_DCMP_LO] <= dedicated_cmp_1_flag & dedicated_cmp_1_irq_en;
      O_IRQ_A[TSF_BIT_GEN_HI] <= general_2_event_flag & general_2_irq_en;
      O_IRQ_A[TSF_BIT_GEN_LO] <= general_1_event_flag & general_1_irq_en;
      O_IRQ_B[TSF_BIT_DCMP_HI] <= dedicated_cmp_4_flag & dedicated_cmp_4_irq_en;
      O_IRQ_B[TSF_BIT_DCMP_LO] <= dedicated_cmp_3_flag & dedicated_cmp_3_irq_en;
      O_IRQ_B[TSF_BIT_GEN_HI] <= general_4_event_flag & general_4_irq_en;
      O_IRQ_B[TSF_BIT_GEN_LO] <= general_3_event_flag & general_3_irq_en;
    end
  end

  // ****************************************
  // read data and bus answer
  // ****************************************
  // fixed-one bits are or-ed in here, so no write can ever reach them
  assign byte_ena = TSF_RST_IRQ_EN_A | {3'h0, irq_en_a_q};
  assign byte_enb = TSF_RST_IRQ_EN_B | {4'h0, irq_en_b_q};
  assign byte_sta = TSF_RST_STATUS_A | {3'h0, status_a_q};
  assign byte_stb = TSF_RST_STATUS_B | {4'h0, status_b_q};

  always_comb begin
    rd_byte = 8'h00;
    if (hit_ena) begin
      rd_byte = byte_ena;
    end else if (hit_enb) begin
      rd_byte = byte_enb;
    end else if (hit_sta) begin
      rd_byte = byte_sta;
    end else if (hit_stb) begin
      rd_byte = byte_stb;
    end
  end

  // data is launched in the setup cycle so it is stable when pready is seen
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PRDATA <= '0;
      O_PSLVERR <= 1'b0;
      O_PREADY <= 1'b0;
    end else begin
      O_PREADY <= i_psel & ~i_penable;
      O_PSLVERR <= i_psel & ~i_penable & ~mapped;
      if (i_psel && !i_penable && !i_pwrite) begin
        O_PRDATA <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_prdata_unused_guard <= 1'b0;
    end else begin
      o_prdata_unused_guard <= 1'b0;
    end
  end

endmodule

// ===== logic/tsf_pkg.sv
/*
 * package for the timer channel status and interrupt-enable flag block.
 * assumes an apb slave with 32-bit data; registers sit in the low byte.
 */
package tsf_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [3:0] TSF_OFS_IRQ_EN_A = 4'h0;
  localparam logic [3:0] TSF_OFS_IRQ_EN_B = 4'h4;
  localparam logic [3:0] TSF_OFS_STATUS_A = 4'h8;
  localparam logic [3:0] TSF_OFS_STATUS_B = 4'hC;

  // ****************************************
  // reset values and fixed-one masks
  // ****************************************
  localparam logic [7:0] TSF_RST_IRQ_EN_A = 8'hE0;
  localparam logic [7:0] TSF_RST_IRQ_EN_B = 8'hF0;
  localparam logic [7:0] TSF_RST_STATUS_A = 8'hE0;
  localparam logic [7:0] TSF_RST_STATUS_B = 8'hF0;
  localparam int TSF_A_BITS = 5;
  localparam int TSF_B_BITS = 4;

  // ****************************************
  // field positions
  // ****************************************
  localparam int TSF_BIT_OVF = 4;
  localparam int TSF_BIT_DCMP_HI = 3;
  localparam int TSF_BIT_DCMP_LO = 2;
  localparam int TSF_BIT_GEN_HI = 1;
  localparam int TSF_BIT_GEN_LO = 0;

  // ****************************************
  // counter
  // ****************************************
  localparam int TSF_CNT_W = 16;
  localparam logic [15:0] TSF_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TSF_CNT_ZERO = 16'h0000;

endpackage

// ===== testbench/testbench.sv
/* self-checking bench for the timer flag block.
   assumes apb answers without wait states; event strobes reach irq in two edges. */
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; \
  $display("Error %s exp %h got %h", nm, e, s); end end
module testbench;
  import tsf_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic arm = 1'b0, tick = 1'b0, rdy, err, se;
  logic [11:0] addr = 12'h000;
  logic [31:0] wd = 32'h0, rdata, q;
  logic [15:0] cnt = 16'h0000;
  logic [7:0] ev = 8'h00, start;
  logic [4:0] irq_a;
  logic [3:0] irq_b;
  int fail_count = 0, n_compared = 0, cyc = 0;
  always #5 clk = ~clk;
  tsf_flags u_dut (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .i_pstrb(4'hF), .o_prdata_unused_guard(),
    .O_PRDATA(rdata), .O_PREADY(rdy), .O_PSLVERR(err), .I_COUNT(cnt), .I_COUNT_TICK(tick),
    .I_DCMP_1_MATCH(ev[2]), .I_DCMP_2_MATCH(ev[3]), .I_DCMP_3_MATCH(ev[6]),
    .I_DCMP_4_MATCH(ev[7]), .I_GEN_1_EVENT(ev[0]), .I_GEN_2_EVENT(ev[1]),
    .I_GEN_3_EVENT(ev[4]), .I_GEN_4_EVENT(ev[5]), .I_XFER_START_A(start[3:0]),
    .I_XFER_START_B(start[7:4]), .O_IRQ_A(irq_a), .O_IRQ_B(irq_b));
  tsf_xfer_model u_xfer (.i_clk(clk), .i_rst_n(rst_n), .i_arm(arm),
    .i_req({irq_b, irq_a[3:0]}), .o_start(start));
  // ****************************************
  // tasks
  // ****************************************
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    q = rdata;
    se = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    apb(a, 1'b0, 8'h00);
    `CHK(nm, {24'h0, e}, q)
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    repeat (2) @(posedge clk);
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h000, 8'hE0, "en_a");
    rd(12'h004, 8'hF0, "en_b");
    apb(12'h008, 1'b1, 8'hFF);
    apb(12'h00C, 1'b1, 8'hFF);
    rd(12'h008, 8'hE0, "st_a");
    rd(12'h00C, 8'hF0, "st_b");
    rd(12'h010, 8'h00, "unmapped");
    `CHK("slverr", 1'b1, se)
    apb(12'h000, 1'b1, 8'h1F);
    apb(12'h004, 1'b1, 8'h0F);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      `CHK("irq", 8'hFF >> (7 - i), {irq_b, irq_a[3:0]})
    end
    apb(12'h008, 1'b1, 8'h00);
    rd(12'h008, 8'hEF, "no arm");
    ev <= 8'h08;
    apb(12'h008, 1'b1, 8'h00);
    ev <= 8'h00;
    rd(12'h008, 8'hE8, "set wins");
    rd(12'h00C, 8'hFF, "arm b");
    apb(12'h00C, 1'b1, 8'h0C);
    rd(12'h00C, 8'hFC, "clr b");
    apb(12'h004, 1'b1, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("irq_b off", 4'h0, irq_b)
    apb(12'h004, 1'b1, 8'h08);
    repeat (2) @(posedge clk);
    `CHK("irq_b on", 4'h8, irq_b)
    cnt <= 16'hFFFF;
    tick <= 1'b1;
    @(posedge clk);
    cnt <= 16'h0000;
    @(posedge clk);
    tick <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("ovf", 1'b1, irq_a[4])
    arm <= 1'b1;
    for (int n = 0; n < 20 && irq_b[3] !== 1'b0; n++) @(posedge clk);
    arm <= 1'b0;
    rd(12'h008, 8'hF0, "xfer a");
    rd(12'h00C, 8'hF4, "xfer b");
    report_and_stop();
  end
endmodule

// ===== testbench/tsf_flags_assertions.sv
/* checker for the timer flag block ports.
   assumes one clock and an async active-low reset. */
`timescale 1ns/10ps
module tsf_chk
  import tsf_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_ARST_N,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic [15:0] I_COUNT,
  input wire logic I_COUNT_TICK,
  input wire logic I_DCMP_2_MATCH,
  input wire logic I_DCMP_4_MATCH,
  input wire logic I_GEN_2_EVENT,
  input wire logic [3:0] I_XFER_START_A,
  input wire logic [3:0] I_XFER_START_B,
  input wire logic [4:0] O_IRQ_A,
  input wire logic [3:0] O_IRQ_B
);
  // ****************************************
  // helpers
  // ****************************************
  logic [15:0] cnt_q;
  logic acc, wacc, ovf;
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= I_COUNT;
    end
  end
  assign acc = i_psel && i_penable && O_PREADY;
  assign wacc = acc && i_pwrite;
  assign ovf = I_COUNT_TICK && I_COUNT == 16'h0000 && cnt_q == 16'hFFFF;
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);
  property p_ro_a; acc && !i_pwrite && i_paddr == 12'h008 |-> O_PRDATA[7:5] == 3'h7; endproperty
  a_ro_a: assert property (p_ro_a) else $error("status a high bits");
  property p_ro_b; acc && !i_pwrite && i_paddr == 12'h00C |-> O_PRDATA[7:4] == 4'hF; endproperty
  a_ro_b: assert property (p_ro_b) else $error("status b high bits");
  property p_a3; $rose(O_IRQ_A[3]) |-> $past(I_DCMP_2_MATCH, 2) || $past(wacc, 2); endproperty
  a_a3: assert property (p_a3) else $error("irq a3 without cause");
  property p_b3; $rose(O_IRQ_B[3]) |-> $past(I_DCMP_4_MATCH, 2) || $past(wacc, 2); endproperty
  a_b3: assert property (p_b3) else $error("irq b3 without cause");
  property p_a1; $rose(O_IRQ_A[1]) |-> $past(I_GEN_2_EVENT, 2) || $past(wacc, 2); endproperty
  a_a1: assert property (p_a1) else $error("irq a1 without cause");
  property p_ovf; $rose(O_IRQ_A[4]) |-> $past(ovf, 2) || $past(wacc, 2); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow irq without wrap");
  property p_xf; I_XFER_START_A[3] && !I_DCMP_2_MATCH ##1 !I_DCMP_2_MATCH |=> !O_IRQ_A[3];
  endproperty
  a_xf: assert property (p_xf) else $error("transfer start left flag");
  property p_b0; $fell(O_IRQ_B[0]) |-> $past(wacc, 2) || $past(I_XFER_START_B[0], 2); endproperty
  a_b0: assert property (p_b0) else $error("flag b0 dropped alone");
  c_ovf: cover property (ovf);
  c_xf: cover property (I_XFER_START_A[3]);
  c_b0: cover property ($fell(O_IRQ_B[0]));
endmodule
bind tsf_flags tsf_chk u_chk (.*);

// ===== testbench/tsf_xfer_model.sv
/* transfer controller model: one start per raised match request.
   assumes registered request levels from the flag block. */
`timescale 1ns/10ps
module tsf_xfer_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_arm,
  input wire logic [7:0] i_req,
  output logic [7:0] o_start
);
  logic [7:0] hold_q;
  // the request drops two edges after a start, so repeats are held off
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_start <= 8'h00;
      hold_q <= 8'h00;
    end else begin
      o_start <= i_arm ? (i_req & ~o_start & ~hold_q) : 8'h00;
      hold_q <= o_start;
    end
  end
endmodule
